//--- include/oau_pkg.sv
// Contract
// - Mode 000 uses the selected register as the operand; mode 001 uses its contents as the address and leaves it unchanged.
// - Mode 010 uses the register as the address, then increments the register.
// - Mode 100 decrements the register first, then uses the new value as the address.
// - Mode 110 fetches the next instruction word and adds it to the register to form the address, changing neither.
// - Mode 011 reads the word the register points at as the address, then adds two to the register, even for bytes.
// - Mode 101 subtracts two from the register, even for bytes, then reads the word there as the address.
// - Mode 111 adds the next instruction word to the register and reads the word at the sum as the address, changing neither.
// - With the program counter selected, 010 is immediate, 011 absolute and 110 relative, all through the same decode.
// - Subroutine linkage and interrupt stack moves use register six as the hardware stack pointer.
// - Register seven is the program counter and goes through the same mode decode as the others.
// - Operands may be 16-bit words or 8-bit bytes.
// - Execution time is the basic time plus the cycles spent locating operands.
// - Sequencing runs on a processor cycle of nominally 260 ns.
package oau_pkg;
   // ===========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROC_CYCLE_NS = 260;
   localparam int TICK_CYCLES =
      (PROC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
   localparam logic [4:0] TICK_ZERO = 5'h00;
   localparam logic [4:0] TICK_ONE = 5'h01;

   // ===========================================================
   // Datapath
   localparam int WORD_W = 16;
   localparam int REG_COUNT = 8;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [2:0] SP_INDEX = 3'h6;
   localparam logic [2:0] PC_INDEX = 3'h7;
   localparam logic [7:0] CYCLE_ZERO = 8'h00;
   localparam logic [7:0] CYCLE_ONE = 8'h01;

   // ===========================================================
   // Specifier layout
   localparam int SPEC_MODE_HI = 5;
   localparam int SPEC_MODE_LO = 3;
   localparam int SPEC_REG_HI = 2;
   localparam int SPEC_REG_LO = 0;

   // ===========================================================
   // Modes
   localparam logic [2:0] MODE_REG = 3'h0;
   localparam logic [2:0] MODE_REG_DEF = 3'h1;
   localparam logic [2:0] MODE_AUTOINC = 3'h2;
   localparam logic [2:0] MODE_AUTOINC_DEF = 3'h3;
   localparam logic [2:0] MODE_AUTODEC = 3'h4;
   localparam logic [2:0] MODE_AUTODEC_DEF = 3'h5;
   localparam logic [2:0] MODE_INDEX = 3'h6;
   localparam logic [2:0] MODE_INDEX_DEF = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DECODE, ST_MREQ, ST_MREL, ST_SUM, ST_FINISH
   } oau_state_e;

   typedef enum logic {
      FETCH_INDEX, FETCH_POINTER
   } oau_fetch_e;

   // Register steps after the address is handed out
   function automatic logic oau_post_step(input logic [2:0] mode);
      oau_post_step = (mode == MODE_AUTOINC) || (mode == MODE_AUTOINC_DEF);
   endfunction : oau_post_step

   // Register steps before the address is formed
   function automatic logic oau_pre_step(input logic [2:0] mode);
      oau_pre_step = (mode == MODE_AUTODEC) || (mode == MODE_AUTODEC_DEF);
   endfunction : oau_pre_step
endpackage : oau_pkg

//--- include/oau_tick_if.sv
`timescale 1ns/1ps
// ==============================================================
// Processor cycle strobe
interface oau_tick_if;
   logic tick;
   modport timer (output tick);
   modport user (input tick);
endinterface : oau_tick_if

//--- hdl/oau_cycle_timer.sv
`timescale 1ns/1ps
// ==============================================================
// Processor cycle timer
module oau_cycle_timer
   import oau_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   oau_tick_if.timer tickBus
);
   logic [4:0] count_ff;
   logic tick_ff;
   logic atLast;
   logic [4:0] nxt_count;

   assign atLast = (count_ff == TICK_LAST);
   assign nxt_count = atLast ? TICK_ZERO : count_ff + TICK_ONE;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_ff <= TICK_ZERO;
         tick_ff <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         tick_ff <= atLast;
      end
   end

   assign tickBus.tick = tick_ff;
endmodule : oau_cycle_timer

//--- hdl/oau_operand_address_unit.sv
`timescale 1ns/1ps
// ==============================================================
// Operand address unit
module oau_operand_address_unit
   import oau_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [5:0] specifier,
   input wire logic byteOp,
   input wire logic [7:0] basicCycles,
   input wire logic memAck,
   input wire logic [15:0] memRdata,
   input wire logic regWrEn,
   input wire logic [2:0] regWrIdx,
   input wire logic [15:0] regWrData,
   input wire logic [2:0] regRdIdx,
   input wire logic stackPush,
   input wire logic stackPop,
   output logic busy,
   output logic done,
   output logic operandIsReg,
   output logic [2:0] operandReg,
   output logic [15:0] operandAddr,
   output logic operandByte,
   output logic [7:0] addrCycles,
   output logic [7:0] totalCycles,
   output logic memReq,
   output logic [15:0] memAddr,
   output logic [15:0] regRdData,
   output logic [15:0] stackPointer,
   output logic [15:0] programCounter
);
   // ===========================================================
   // Cycle timer
   oau_tick_if tickBus ();

   oau_cycle_timer timer (
      .clk(clk),
      .reset_n(reset_n),
      .tickBus(tickBus)
   );

   logic tick;
   assign tick = tickBus.tick;

   // ===========================================================
   // State
   oau_state_e state_ff, nxt_state;
   oau_fetch_e fetch_ff, nxt_fetch;
   logic [15:0] gpr_ff [REG_COUNT];
   logic [2:0] mode_ff;
   logic [2:0] sel_ff;
   logic byte_ff;
   logic [15:0] word_ff;
   logic [15:0] ea_ff, nxt_ea;
   logic [15:0] memAddr_ff, nxt_memAddr;
   logic memReq_ff;
   logic ackMeta_ff, ackSync_ff;
   logic [15:0] rdMeta_ff, rdSync_ff;
   logic [7:0] cycles_ff;
   logic [7:0] basic_ff;
   logic busy_ff, done_ff, isReg_ff, opByte_ff;
   logic [2:0] opReg_ff;
   logic [15:0] opAddr_ff;
   logic [7:0] addrCycles_ff, totalCycles_ff;
   logic [15:0] regRd_ff;

   // ===========================================================
   // Decode
   logic [2:0] specMode, specReg;
   logic [15:0] selVal, stepSize, sumVal;
   logic idle, accept, finishing;

   assign specMode = specifier[SPEC_MODE_HI:SPEC_MODE_LO];
   assign specReg = specifier[SPEC_REG_HI:SPEC_REG_LO];
   assign selVal = gpr_ff[sel_ff];
   assign stepSize = (byte_ff && (sel_ff < SP_INDEX) &&
                      (mode_ff == MODE_AUTOINC ||
                       mode_ff == MODE_AUTODEC))
                     ? BYTE_STEP : WORD_STEP;
   assign sumVal = word_ff + selVal;
   assign idle = (state_ff == ST_IDLE);
   assign accept = idle && start;
   assign finishing = (state_ff == ST_FINISH) && tick;

   // ===========================================================
   // Register update selection
   logic updMode, updStack, updExt, regUpd;
   logic [2:0] regUpdIdx;
   logic [15:0] regUpdVal;

   assign updMode = tick &&
      (((state_ff == ST_DECODE) &&
        (oau_pre_step(mode_ff) || mode_ff[2:1] == MODE_INDEX[2:1])) ||
       ((state_ff == ST_FINISH) && oau_post_step(mode_ff)));
   assign updStack = idle && !start && (stackPush ^ stackPop);
   assign updExt = idle && !start && !updStack && regWrEn;
   assign regUpd = updMode || updStack || updExt;
   assign regUpdIdx = updMode ?
      ((state_ff == ST_DECODE && mode_ff[2:1] == MODE_INDEX[2:1])
       ? PC_INDEX : sel_ff) :
      (updStack ? SP_INDEX : regWrIdx);
   assign regUpdVal =
      !updMode ? (updStack ? (stackPush ? gpr_ff[SP_INDEX] - WORD_STEP
                                        : gpr_ff[SP_INDEX] + WORD_STEP)
                           : regWrData) :
      (state_ff == ST_FINISH) ? selVal + stepSize :
      oau_pre_step(mode_ff) ? selVal - stepSize :
      gpr_ff[PC_INDEX] + WORD_STEP;

   // ===========================================================
   // Sequencer
   always_comb
   begin
      nxt_state = state_ff;
      nxt_fetch = fetch_ff;
      nxt_ea = ea_ff;
      nxt_memAddr = memAddr_ff;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (start)
               nxt_state = ST_DECODE;
         end
         ST_DECODE:
         begin
            if (tick)
            begin
               unique case (mode_ff)
                  MODE_REG, MODE_REG_DEF, MODE_AUTOINC:
                  begin
                     nxt_ea = selVal;
                     nxt_state = ST_FINISH;
                  end
                  MODE_AUTODEC:
                  begin
                     nxt_ea = selVal - stepSize;
                     nxt_state = ST_FINISH;
                  end
                  MODE_AUTOINC_DEF:
                  begin
                     nxt_memAddr = selVal;
                     nxt_fetch = FETCH_POINTER;
                     nxt_state = ST_MREQ;
                  end
                  MODE_AUTODEC_DEF:
                  begin
                     nxt_memAddr = selVal - WORD_STEP;
                     nxt_fetch = FETCH_POINTER;
                     nxt_state = ST_MREQ;
                  end
                  MODE_INDEX, MODE_INDEX_DEF:
                  begin
                     nxt_memAddr = gpr_ff[PC_INDEX];
                     nxt_fetch = FETCH_INDEX;
                     nxt_state = ST_MREQ;
                  end
               endcase
            end
         end
         ST_MREQ:
         begin
            if (tick && ackSync_ff)
               nxt_state = ST_MREL;
         end
         ST_MREL:
         begin
            if (tick && !ackSync_ff)
            begin
               if (fetch_ff == FETCH_INDEX)
                  nxt_state = ST_SUM;
               else
               begin
                  nxt_ea = word_ff;
                  nxt_state = ST_FINISH;
               end
            end
         end
         ST_SUM:
         begin
            if (tick)
            begin
               if (mode_ff == MODE_INDEX)
               begin
                  nxt_ea = sumVal;
                  nxt_state = ST_FINISH;
               end
               else
               begin
                  nxt_memAddr = sumVal;
                  nxt_fetch = FETCH_POINTER;
                  nxt_state = ST_MREQ;
               end
            end
         end
         ST_FINISH:
         begin
            if (tick)
               nxt_state = ST_IDLE;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // ===========================================================
   // Bus synchronisers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ackMeta_ff <= 1'b0;
         ackSync_ff <= 1'b0;
         rdMeta_ff <= RESET_WORD;
         rdSync_ff <= RESET_WORD;
      end
      else
      begin
         ackMeta_ff <= memAck;
         ackSync_ff <= ackMeta_ff;
         rdMeta_ff <= memRdata;
         rdSync_ff <= rdMeta_ff;
      end
   end

   // ===========================================================
   // Register file
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            gpr_ff[i] <= RESET_WORD;
      end
      else if (regUpd)
         gpr_ff[regUpdIdx] <= regUpdVal;
   end

   // ===========================================================
   // Control registers
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= ST_IDLE;
         fetch_ff <= FETCH_INDEX;
         mode_ff <= MODE_REG;
         sel_ff <= 3'h0;
         byte_ff <= 1'b0;
         basic_ff <= CYCLE_ZERO;
         ea_ff <= RESET_WORD;
         memAddr_ff <= RESET_WORD;
         memReq_ff <= 1'b0;
         word_ff <= RESET_WORD;
         cycles_ff <= CYCLE_ZERO;
      end
      else
      begin
         state_ff <= nxt_state;
         fetch_ff <= nxt_fetch;
         ea_ff <= nxt_ea;
         memAddr_ff <= nxt_memAddr;
         memReq_ff <= (nxt_state == ST_MREQ);
         if (accept)
         begin
            mode_ff <= specMode;
            sel_ff <= specReg;
            byte_ff <= byteOp;
            basic_ff <= basicCycles;
         end
         if (state_ff == ST_MREQ && ackSync_ff)
            word_ff <= rdSync_ff;
         if (accept)
            cycles_ff <= CYCLE_ZERO;
         else if (!idle && tick)
            cycles_ff <= cycles_ff + CYCLE_ONE;
      end
   end

   // ===========================================================
   // Outputs
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         isReg_ff <= 1'b0;
         opReg_ff <= 3'h0;
         opAddr_ff <= RESET_WORD;
         opByte_ff <= 1'b0;
         addrCycles_ff <= CYCLE_ZERO;
         totalCycles_ff <= CYCLE_ZERO;
         regRd_ff <= RESET_WORD;
      end
      else
      begin
         busy_ff <= (nxt_state != ST_IDLE);
         done_ff <= finishing;
         regRd_ff <= gpr_ff[regRdIdx];
         if (finishing)
         begin
            isReg_ff <= (mode_ff == MODE_REG);
            opReg_ff <= sel_ff;
            opAddr_ff <= ea_ff;
            opByte_ff <= byte_ff;
            addrCycles_ff <= cycles_ff + CYCLE_ONE;
            totalCycles_ff <= basic_ff + cycles_ff + CYCLE_ONE;
         end
      end
   end

   assign busy = busy_ff;
   assign done = done_ff;
   assign operandIsReg = isReg_ff;
   assign operandReg = opReg_ff;
   assign operandAddr = opAddr_ff;
   assign operandByte = opByte_ff;
   assign addrCycles = addrCycles_ff;
   assign totalCycles = totalCycles_ff;
   assign memReq = memReq_ff;
   assign memAddr = memAddr_ff;
   assign regRdData = regRd_ff;
   assign stackPointer = gpr_ff[SP_INDEX];
   assign programCounter = gpr_ff[PC_INDEX];
endmodule : oau_operand_address_unit

//--- tb/oau_mem_model.sv
`timescale 1ns/1ps
// ============================================================
// Memory behind the system bus, four-phase read responder
module oau_mem_model (
   input wire logic clk,
   input wire logic [3:0] lag,
   input wire logic memReq,
   input wire logic [15:0] memAddr,
   output logic memAck,
   output logic [15:0] memRdata
);
   // Stored word, scrambled so neighbouring addresses differ
   function automatic logic [15:0] memWord(input logic [15:0] a);
      return {a[7:0], a[15:8]} ^ 16'h3C5A;
   endfunction : memWord

   initial
   begin
      memAck = 1'b0;
      memRdata = 16'hFFFF;
      forever
      begin
         @(posedge clk);
         if (memReq === 1'b1)
         begin
            repeat (lag) @(posedge clk);
            memRdata <= memWord(memAddr);
            // Data settles three cycles ahead of the acknowledge
            repeat (3) @(posedge clk);
            memAck <= 1'b1;
            while (memReq !== 1'b0) @(posedge clk);
            memAck <= 1'b0;
            @(posedge clk);
            // Released lines no longer show the last word
            memRdata <= ~memRdata;
         end
      end
   end
endmodule : oau_mem_model

//--- tb/oau_operand_address_unit_props.sv
`timescale 1ns/1ps
// ============================================================
// Operand address unit checker
module oau_operand_address_unit_props
   import oau_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [5:0] specifier,
   input wire logic stackPush,
   input wire logic stackPop,
   input wire logic busy,
   input wire logic done,
   input wire logic operandIsReg,
   input wire logic [2:0] operandReg,
   input wire logic [15:0] operandAddr,
   input wire logic [15:0] stackPointer,
   input wire logic [15:0] programCounter
);
   logic [37:0] held_ff;
   logic [7:0] waitCnt_ff;
   wire logic taken = start && !busy;
   wire logic [37:0] nxt_held = taken ?
      {specifier, stackPointer, programCounter} : held_ff;
   wire logic [7:0] nxt_waitCnt = taken ? 8'h01 :
      waitCnt_ff + {7'h00, busy && waitCnt_ff != 8'hFF};
   wire logic [2:0] heldMode = held_ff[37:35];
   wire logic [2:0] heldReg = held_ff[34:32];
   wire logic [15:0] heldSp = held_ff[31:16];
   wire logic [15:0] heldPc = held_ff[15:0];

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         held_ff <= 38'h0;
         waitCnt_ff <= 8'h00;
      end
      else
      begin
         held_ff <= nxt_held;
         waitCnt_ff <= nxt_waitCnt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence accepted;
      start && !busy;
   endsequence
   sequence finished(logic [2:0] m, logic [2:0] r);
      done && heldMode == m && heldReg == r;
   endsequence

   startBusy_a: assert property (accepted |=> busy [*2])
      else $error("busy not raised by start");
   regOperand_a: assert property (
      done && heldMode == MODE_REG |->
      operandIsReg && operandReg == heldReg)
      else $error("register operand wrong");
   defNoChange_a: assert property (
      finished(MODE_REG_DEF, SP_INDEX) |-> !operandIsReg &&
      operandAddr == heldSp && stackPointer == heldSp)
      else $error("deferred operand wrong");
   incAfter_a: assert property (
      finished(MODE_AUTOINC, SP_INDEX) |->
      operandAddr == heldSp && stackPointer == heldSp + WORD_STEP)
      else $error("autoincrement wrong");
   decBefore_a: assert property (
      finished(MODE_AUTODEC, SP_INDEX) |->
      stackPointer == heldSp - WORD_STEP && operandAddr == stackPointer)
      else $error("autodecrement wrong");
   pcImmediate_a: assert property (
      finished(MODE_AUTOINC, PC_INDEX) |-> operandAddr == heldPc &&
      programCounter == heldPc + WORD_STEP)
      else $error("immediate operand wrong");
   cycleTime_a: assert property (
      done && heldMode == MODE_REG |-> waitCnt_ff inside {[27:56]})
      else $error("register mode time wrong");
   pushStep_a: assert property (
      stackPush && !stackPop && !start && !busy |=>
      stackPointer == $past(stackPointer) - WORD_STEP)
      else $error("stack push step wrong");
endmodule : oau_operand_address_unit_props

bind oau_operand_address_unit oau_operand_address_unit_props
   oau_operand_address_unit_props_inst (.clk, .reset_n, .start,
   .specifier, .stackPush, .stackPop, .busy, .done, .operandIsReg,
   .operandReg, .operandAddr, .stackPointer, .programCounter);

//--- tb/operand_address_unit_tb.sv
`timescale 1ns/1ps
// ============================================================
// Operand address unit testbench
module operand_address_unit_tb;
   import oau_pkg::*;
   logic clk, reset_n, start, byteOp, memAck, regWrEn, stackPush, stackPop;
   logic busy, done, operandIsReg, operandByte, memReq;
   logic [5:0] specifier;
   logic [7:0] basicCycles, addrCycles, totalCycles;
   logic [2:0] regWrIdx, regRdIdx, operandReg;
   logic [3:0] lag;
   logic [15:0] memRdata, regWrData, operandAddr, memAddr, regRdData;
   logic [15:0] stackPointer, programCounter;
   logic [15:0] gpr [8];
   logic [6:0] corner [12];
   int errCount, comparisons;

   oau_operand_address_unit oau_operand_address_unit_inst (
      .clk, .reset_n, .start, .specifier, .byteOp, .basicCycles, .memAck,
      .memRdata, .regWrEn, .regWrIdx, .regWrData, .regRdIdx, .stackPush,
      .stackPop, .busy, .done, .operandIsReg, .operandReg, .operandAddr,
      .operandByte, .addrCycles, .totalCycles, .memReq, .memAddr,
      .regRdData, .stackPointer, .programCounter);
   oau_mem_model oau_mem_model_inst (
      .clk, .lag, .memReq, .memAddr, .memAck, .memRdata);

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errCount++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chkCycles(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errCount++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chkCycles

   // Processor cycles spent locating the operand in each mode
   function automatic logic [7:0] expCycles(input logic [2:0] m);
      case (m)
         MODE_AUTOINC_DEF, MODE_AUTODEC_DEF: return 8'h04;
         MODE_INDEX: return 8'h05;
         MODE_INDEX_DEF: return 8'h07;
         default: return 8'h02;
      endcase
   endfunction : expCycles

   task automatic endOfTest;
      if (errCount == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : endOfTest

   task automatic writeReg(input logic [2:0] i, input logic [15:0] v);
      @(negedge clk);
      regWrEn = 1'b1;
      regWrIdx = i;
      regWrData = v;
      @(negedge clk);
      regWrEn = 1'b0;
      gpr[i] = v;
   endtask : writeReg

   task automatic runOp(input logic [2:0] m, input logic [2:0] r,
      input logic b);
      logic [15:0] addr;
      logic [15:0] x;
      logic [15:0] step;
      logic [15:0] ptr;
      int n;
      step = (b && m inside {MODE_AUTOINC, MODE_AUTODEC} && r < SP_INDEX)
         ? BYTE_STEP : WORD_STEP;
      x = 16'h0000;
      ptr = gpr[PC_INDEX];
      if (m >= MODE_INDEX)
      begin
         x = oau_mem_model_inst.memWord(gpr[PC_INDEX]);
         gpr[PC_INDEX] += WORD_STEP;
      end
      if (m inside {MODE_AUTODEC, MODE_AUTODEC_DEF})
         gpr[r] -= step;
      addr = x + gpr[r];
      if (m != MODE_INDEX)
         ptr = addr;
      if (m inside {MODE_AUTOINC_DEF, MODE_AUTODEC_DEF, MODE_INDEX_DEF})
         addr = oau_mem_model_inst.memWord(addr);
      if (m inside {MODE_AUTOINC, MODE_AUTOINC_DEF})
         gpr[r] += step;
      @(negedge clk);
      start = 1'b1;
      specifier = {m, r};
      byteOp = b;
      basicCycles = 8'($urandom);
      lag = 4'($urandom_range(0, 6));
      @(negedge clk);
      start = 1'b0;
      // Register load while busy must be ignored
      regWrEn = 1'b1;
      regWrIdx = r;
      regWrData = ~gpr[r];
      @(negedge clk);
      regWrEn = 1'b0;
      for (n = 0; done !== 1'b1 && n < 2000; n++)
         @(negedge clk);
      chk(16'(done), 16'h0001);
      chk(16'(operandIsReg), 16'(m == MODE_REG));
      if (m == MODE_REG)
         chk(16'(operandReg), 16'(r));
      else
         chk(operandAddr, addr);
      chk(16'(operandByte), 16'(b));
      chk(programCounter, gpr[PC_INDEX]);
      chkCycles(addrCycles, expCycles(m));
      chkCycles(totalCycles, 8'(basicCycles + expCycles(m)));
      if (m inside {MODE_AUTOINC_DEF, MODE_AUTODEC_DEF, MODE_INDEX,
         MODE_INDEX_DEF})
         chk(memAddr, ptr);
      chk(16'(memReq), 16'h0000);
      regRdIdx = r;
      @(negedge clk);
      chk(regRdData, gpr[r]);
   endtask : runOp

   initial
   begin
      {start, specifier, byteOp, basicCycles, regWrEn, regWrIdx} = '0;
      {regWrData, regRdIdx, stackPush, stackPop, lag} = '0;
      reset_n = 1'b0;
      foreach (gpr[i]) gpr[i] = RESET_WORD;
      corner = '{{MODE_REG_DEF, 3'h6, 1'b0}, {MODE_AUTOINC, 3'h6, 1'b1},
         {MODE_AUTODEC, 3'h6, 1'b0}, {MODE_REG, 3'h6, 1'b0},
         {MODE_AUTOINC, 3'h7, 1'b0}, {MODE_AUTOINC_DEF, 3'h7, 1'b0},
         {MODE_INDEX, 3'h7, 1'b0}, {MODE_INDEX_DEF, 3'h7, 1'b0},
         {MODE_AUTODEC, 3'h0, 1'b1}, {MODE_AUTODEC_DEF, 3'h0, 1'b1},
         {MODE_AUTOINC, 3'h5, 1'b1}, {MODE_AUTOINC_DEF, 3'h1, 1'b1}};
      void'($urandom(32'h9592B7AE));
      repeat (2) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      writeReg(SP_INDEX, 16'h1000);
      foreach (corner[k])
         runOp(corner[k][6:4], corner[k][3:1], corner[k][0]);
      for (int k = 0; k < 3; k++)
      begin
         @(negedge clk);
         stackPush = (k != 1);
         stackPop = (k != 0);
         @(negedge clk);
         {stackPush, stackPop} = 2'h0;
         gpr[SP_INDEX] += (k == 0) ? -WORD_STEP : (k == 1) ? WORD_STEP : 16'h0;
         chk(stackPointer, gpr[SP_INDEX]);
      end
      repeat (40)
      begin
         writeReg(3'($urandom), 16'($urandom) & 16'hFFFE);
         runOp(3'($urandom), 3'($urandom), 1'($urandom));
      end
      endOfTest();
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      errCount++;
      endOfTest();
   end
endmodule : operand_address_unit_tb
